// ===== usbdte_engine.sv
// Design decisions made here: the Wishbone interface to the registers and the register addresses.
`include "usbdte_map.svh"

// Behaviour
// - rx write-back puts the received byte count into byte_count
// - no packet longer than 64 bytes is moved in either direction
// - buffer address is buffer_start_addr with four zero low bits
// - the buffer_start_addr byte of a descriptor is never written
// - descriptor address comes from endpoint, direction and odd select
// - data moves only when holder_flag reads 1
// - write-back clears holder_flag, giving the descriptor back
// - after write-back the transfer status updates, then token_done_flag; the code sets both in the same cycle
// - latency overrun answers NAK or silence and sets bus_timeout_error
// - latency overrun writes nothing back and raises no token_done_flag
// - interrupt output follows the interrupt and error mask registers
// - oversized non-isochronous packet is still answered with ACK
// - only max_packet_size bytes of an oversized packet are stored
// - oversized packet sets buffer_overflow_error
// - oversized packet writes back max_packet_size; pid never 1111
// - control request starts with setup token and 8-byte packet
// - optional data phase up to 64 Kbytes, one direction, then status
// - after out phase firmware arms zero-length in status descriptor
// - status direction is opposite to the data phase direction
// - token pid written back as 0x1 out, 0x9 in, 0xd setup
// - while holder_flag is 0 all other descriptor fields are ignored
// - halted descriptor answers STALL and stays unchanged
module usbdte_engine #(
   parameter int RAM_AW     = 10,
   parameter int MAXP_LIMIT = 64
) (
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      cyc_i,
   input  wire logic                      stb_i,
   input  wire logic                      we_i,
   input  wire logic [12:0]               adr_i,
   input  wire logic [3:0]                sel_i,
   input  wire logic [31:0]               dat_i,
   output      logic                      ack_o,
   output      logic [31:0]               dat_o,
   input  wire logic                      tok_valid_i,
   input  wire usbdte_pkg::usbdte_tok_s   tok_i,
   output      logic                      tok_ready_o,
   input  wire logic                      rx_valid_i,
   input  wire logic [7:0]                rx_data_i,
   input  wire logic                      rx_end_i,
   output      logic                      tx_valid_o,
   output      logic [7:0]                tx_data_o,
   output      logic                      tx_last_o,
   input  wire logic                      tx_ready_i,
   output      logic                      hs_valid_o,
   output      logic [3:0]                hs_pid_o,
   output      logic                      irq_o
);
   localparam logic [7:0] LIMIT = 8'(MAXP_LIMIT);

   logic [7:0]                 mem_ff [2**RAM_AW];
   usbdte_pkg::usbdte_state_e  st_ff, nxt_st;
   usbdte_pkg::usbdte_tok_s    tok_ff;
   logic [7:0]                 bd0_ff, bc_ff, ptr_ff, hold_ff, maxp_ff;
   logic [5:0]                 ba_ff;
   logic                       hold_v_ff, ovr_ff, big_ff, end_ff;
   logic [4:0]                 stat_ff;
   logic                       tokdn_ff;
   logic [1:0]                 err_ff, imask_ff, emask_ff;
   logic                       ack_ff, irq_ff, tok_rdy_ff;
   logic [31:0]                dat_ff;
   logic                       hs_v_ff, tx_v_ff, tx_last_ff;
   logic [3:0]                 hs_pid_ff;
   logic [7:0]                 tx_d_ff;

   // bus decode; the bus wins the ram port, the engine waits a cycle
   wire        bus_req  = cyc_i & stb_i & ~ack_ff;
   wire [12:0] bus_a    = {adr_i[12:2], 2'b00};
   wire        bus_ram  = bus_req & adr_i[`UDTE_RAM_SEL];
   wire        bus_wr   = bus_req & we_i & sel_i[0];
   wire        gnt      = ~bus_ram;
   wire        wr_reg   = bus_wr & ~adr_i[`UDTE_RAM_SEL];
   wire        wr_int   = wr_reg & (bus_a == `UDTE_REG_INTERRUPT_STATUS_REG);
   wire        wr_err   = wr_reg & (bus_a == `UDTE_REG_ERROR_STATUS_REG);

   wire        is_in    = tok_ff.pid == `UDTE_PID_IN;
   wire        in_buf   = (st_ff == usbdte_pkg::S_TX) |
                          (st_ff == usbdte_pkg::S_RX);
   wire [RAM_AW-1:0] desc_a = RAM_AW'({tok_ff.ep, is_in, tok_ff.odd, 2'b00});
   wire [RAM_AW-1:0] buf_a  = RAM_AW'({ba_ff, 4'h0}) + RAM_AW'(ptr_ff);
   wire [1:0]  boff     = (st_ff == usbdte_pkg::S_RD1 ||
                           st_ff == usbdte_pkg::S_WB0) ? 2'h1 :
                          (st_ff == usbdte_pkg::S_RD2) ? 2'h2 : 2'h0;
   wire [RAM_AW-1:0] eng_a  = in_buf ? buf_a : (desc_a | RAM_AW'(boff));
   wire [7:0]  eng_rd   = mem_ff[eng_a];

   // receive path: one holding byte between the serial engine and ram
   wire        rx_st    = st_ff == usbdte_pkg::S_RX;
   wire        clip     = ptr_ff >= maxp_ff;
   wire        store    = rx_st & hold_v_ff & ~clip & gnt;
   wire        drain    = rx_st & hold_v_ff & (gnt | clip);
   wire        rx_take  = rx_valid_i & (st_ff != usbdte_pkg::S_IDLE);
   wire        rx_fin   = rx_st & end_ff & ~hold_v_ff;

   // transmit path, length clamped to the module limit
   wire [7:0]  tx_n     = (bc_ff > LIMIT) ? LIMIT : bc_ff;
   wire        tx_free  = ~tx_v_ff | tx_ready_i;
   wire        tx_more  = ptr_ff < tx_n;
   wire        tx_load  = (st_ff == usbdte_pkg::S_TX) & gnt & tx_more &
                          tx_free;
   wire        tx_fin   = (st_ff == usbdte_pkg::S_TX) & ~tx_more & tx_free;

   wire        own      = bd0_ff[`UDTE_BD_OWN];
   wire        halt     = bd0_ff[`UDTE_BD_HALT];
   wire [7:0]  wb_cnt   = is_in ? bc_ff : ptr_ff;
   wire [7:0]  wb_b0    = {1'b0, bd0_ff[`UDTE_BD_D01], tok_ff.pid, 2'b00};
   wire        wb_st    = (st_ff == usbdte_pkg::S_WB0) |
                          (st_ff == usbdte_pkg::S_WB1);
   wire        eng_we   = store | (wb_st & gnt);
   wire [7:0]  eng_wd   = (st_ff == usbdte_pkg::S_WB0) ? wb_cnt :
                          (st_ff == usbdte_pkg::S_WB1) ? wb_b0 : hold_ff;
   wire        done_set = st_ff == usbdte_pkg::S_DONE;
   wire [1:0]  err_set  = {rx_fin & ~ovr_ff & big_ff,
                           rx_fin & ovr_ff};
   wire        err_any  = |(err_ff & emask_ff);
   wire [1:0]  int_word = {err_any, tokdn_ff};
   wire [7:0]  maxp_wr  = (dat_i[7:0] > LIMIT) ? LIMIT : dat_i[7:0];

   wire [31:0] rd_word  =
      adr_i[`UDTE_RAM_SEL]          ? {24'h0, mem_ff[adr_i[RAM_AW+1:2]]} :
      bus_a == `UDTE_REG_STAT       ? {27'h0, stat_ff} :
      bus_a == `UDTE_REG_INTERRUPT_STATUS_REG    ? {30'h0, int_word} :
      bus_a == `UDTE_REG_INTMASK    ? {30'h0, imask_ff} :
      bus_a == `UDTE_REG_ERROR_STATUS_REG    ? {30'h0, err_ff} :
      bus_a == `UDTE_REG_ERRMASK    ? {30'h0, emask_ff} :
      bus_a == `UDTE_REG_MAXPKT     ? {24'h0, maxp_ff} : 32'h0;

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         usbdte_pkg::S_IDLE: if (tok_valid_i) nxt_st = usbdte_pkg::S_RD0;
         usbdte_pkg::S_RD0:  if (gnt) nxt_st = usbdte_pkg::S_RD1;
         usbdte_pkg::S_RD1:  if (gnt) nxt_st = usbdte_pkg::S_RD2;
         usbdte_pkg::S_RD2:  if (gnt) nxt_st = usbdte_pkg::S_CHK;
         usbdte_pkg::S_CHK: begin
            if (!own || halt) begin
               nxt_st = usbdte_pkg::S_IDLE;
            end else if (is_in) begin
               nxt_st = usbdte_pkg::S_TX;
            end else begin
               nxt_st = usbdte_pkg::S_RX;
            end
         end
         usbdte_pkg::S_TX:   if (tx_fin) nxt_st = usbdte_pkg::S_WB0;
         usbdte_pkg::S_RX: begin
            if (rx_fin) begin
               // overrun leaves the descriptor for the retry
               nxt_st = ovr_ff ? usbdte_pkg::S_IDLE : usbdte_pkg::S_WB0;
            end
         end
         usbdte_pkg::S_WB0:  if (gnt) nxt_st = usbdte_pkg::S_WB1;
         usbdte_pkg::S_WB1:  if (gnt) nxt_st = usbdte_pkg::S_DONE;
         usbdte_pkg::S_DONE: nxt_st = usbdte_pkg::S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (bus_ram && bus_wr) begin
         mem_ff[adr_i[RAM_AW+1:2]] <= dat_i[7:0];
      end else if (eng_we) begin
         mem_ff[eng_a] <= eng_wd;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff      <= usbdte_pkg::S_IDLE;
         tok_rdy_ff <= 1'b0;
      end else begin
         st_ff      <= nxt_st;
         tok_rdy_ff <= nxt_st == usbdte_pkg::S_IDLE;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tok_ff  <= '0;
         bd0_ff  <= 8'h0;
         bc_ff   <= 8'h0;
         ba_ff   <= 6'h0;
      end else begin
         if (st_ff == usbdte_pkg::S_IDLE && tok_valid_i) tok_ff <= tok_i;
         if (st_ff == usbdte_pkg::S_RD0 && gnt) bd0_ff <= eng_rd;
         if (st_ff == usbdte_pkg::S_RD1 && gnt) bc_ff <= eng_rd;
         if (st_ff == usbdte_pkg::S_RD2 && gnt) ba_ff <= eng_rd[5:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || st_ff == usbdte_pkg::S_IDLE) begin
         ptr_ff    <= 8'h0;
         hold_ff   <= 8'h0;
         hold_v_ff <= 1'b0;
         ovr_ff    <= 1'b0;
         big_ff    <= 1'b0;
         end_ff    <= 1'b0;
      end else begin
         if (store || tx_load) ptr_ff <= ptr_ff + 8'h1;
         if (rx_take) hold_ff <= rx_data_i;
         hold_v_ff <= rx_take | (hold_v_ff & ~drain);
         // a byte landing on a still-full holder is a latency overrun
         if (rx_take && hold_v_ff && !drain) ovr_ff <= 1'b1;
         if (drain && clip) big_ff <= 1'b1;
         if (rx_end_i) end_ff <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hs_v_ff    <= 1'b0;
         hs_pid_ff  <= 4'h0;
         tx_v_ff    <= 1'b0;
         tx_d_ff    <= 8'h0;
         tx_last_ff <= 1'b0;
      end else begin
         hs_v_ff    <= 1'b0;
         if (st_ff == usbdte_pkg::S_CHK && (!own || halt) && !tok_ff.iso) begin
            hs_v_ff   <= 1'b1;
            hs_pid_ff <= own ? `UDTE_PID_STALL : `UDTE_PID_NAK;
         end else if (rx_fin && !tok_ff.iso) begin
            // isochronous gets no handshake; silence is the timeout
            hs_v_ff   <= 1'b1;
            hs_pid_ff <= ovr_ff ? `UDTE_PID_NAK : `UDTE_PID_ACK;
         end
         if (tx_load) begin
            tx_v_ff    <= 1'b1;
            tx_d_ff    <= eng_rd;
            tx_last_ff <= ptr_ff + 8'h1 == tx_n;
         end else if (st_ff == usbdte_pkg::S_CHK && is_in && own && !halt) begin
            tx_last_ff <= bc_ff == 8'h0;
         end else if (tx_ready_i || !tx_v_ff) begin
            tx_v_ff    <= 1'b0;
            tx_last_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_ff  <= 5'h0;
         tokdn_ff <= 1'b0;
         err_ff   <= 2'h0;
         imask_ff <= `UDTE_MASK_RST;
         emask_ff <= `UDTE_MASK_RST;
         maxp_ff  <= `UDTE_MAXP_RST;
         irq_ff   <= 1'b0;
      end else begin
         if (done_set) stat_ff <= {tok_ff.ep, is_in, tok_ff.odd};
         // a new event beats a clear written in the same cycle
         tokdn_ff <= done_set | (tokdn_ff & ~(wr_int & dat_i[0]));
         err_ff   <= err_set | (err_ff & ~(wr_err ? dat_i[1:0] : 2'h0));
         if (wr_reg && bus_a == `UDTE_REG_INTMASK) imask_ff <= dat_i[1:0];
         if (wr_reg && bus_a == `UDTE_REG_ERRMASK) emask_ff <= dat_i[1:0];
         if (wr_reg && bus_a == `UDTE_REG_MAXPKT) maxp_ff <= maxp_wr;
         irq_ff   <= |(int_word & imask_ff);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
      end else begin
         ack_ff <= bus_req;
         if (bus_req) dat_ff <= rd_word;
      end
   end

   assign ack_o       = ack_ff;
   assign dat_o       = dat_ff;
   assign tok_ready_o = tok_rdy_ff;
   assign tx_valid_o  = tx_v_ff;
   assign tx_data_o   = tx_d_ff;
   assign tx_last_o   = tx_last_ff;
   assign hs_valid_o  = hs_v_ff;
   assign hs_pid_o    = hs_pid_ff;
   assign irq_o       = irq_ff;

   a_tx_needs_own: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(st_ff == usbdte_pkg::S_TX) |-> $past(own) && !$past(halt))
      else $error("transmit started without ownership");
   a_clear_owner: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == usbdte_pkg::S_WB1 && gnt) |-> !eng_wd[7] &&
      eng_wd[5:2] != 4'hf)
      else $error("write-back kept holder flag or bad pid");
   a_addr_kept: assert property (@(posedge clk_i) disable iff (rst_i)
      (eng_we && !in_buf) |-> eng_a[1:0] != 2'h2)
      else $error("buffer address byte written");
   a_done_order: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(tokdn_ff) |-> $past(st_ff, 2) == usbdte_pkg::S_WB1)
      else $error("done flag before write-back");
   a_overrun_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_fin && ovr_ff) |=> st_ff == usbdte_pkg::S_IDLE ##1
      st_ff != usbdte_pkg::S_DONE)
      else $error("overrun reached write-back");
   a_overrun_err: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_fin && ovr_ff) |=> err_ff[`UDTE_ERR_BTO] &&
      (tok_ff.iso || hs_pid_o == `UDTE_PID_NAK))
      else $error("overrun not flagged");
   a_big_ack: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_fin && !ovr_ff && big_ff && !tok_ff.iso) |=>
      hs_valid_o && hs_pid_o == `UDTE_PID_ACK && err_ff[`UDTE_ERR_BUF])
      else $error("oversized packet not acked or flagged");
   a_clip_len: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == usbdte_pkg::S_WB0 && !is_in) |-> eng_wd <= maxp_ff)
      else $error("stored length beyond max packet");
   a_halt_stall: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == usbdte_pkg::S_CHK && own && halt && !tok_ff.iso) |=>
      hs_valid_o && hs_pid_o == `UDTE_PID_STALL ##1
      st_ff != usbdte_pkg::S_WB0)
      else $error("halted descriptor not stalled");
   a_irq_mask: assert property (@(posedge clk_i) disable iff (rst_i)
      (imask_ff == 2'h0) [*2] |-> !irq_o)
      else $error("interrupt while masked");
   a_rx_owned: assert property (@(posedge clk_i) disable iff (rst_i)
      store |-> own && !halt)
      else $error("data stored without ownership");
   a_big_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      (rx_fin && !ovr_ff && big_ff) |=> err_ff[`UDTE_ERR_BUF])
      else $error("oversized packet not flagged");
   a_stat_done: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == usbdte_pkg::S_DONE) |=> tokdn_ff &&
      stat_ff == {tok_ff.ep, is_in, tok_ff.odd})
      else $error("status or done flag not updated");
   a_pid_code: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == usbdte_pkg::S_WB1 && gnt) |-> eng_wd[5:2] == `UDTE_PID_OUT ||
      eng_wd[5:2] == `UDTE_PID_IN || eng_wd[5:2] == `UDTE_PID_SETUP)
      else $error("written-back pid not a token code");
   a_count_slot: assert property (@(posedge clk_i) disable iff (rst_i)
      (st_ff == usbdte_pkg::S_WB0 && gnt) |-> eng_a[1:0] == 2'h1 &&
      eng_wd <= LIMIT)
      else $error("count written to wrong byte or too large");
endmodule // usbdte_engine

// ===== usbdte_map.svh
`ifndef USBDTE_MAP_SVH
`define USBDTE_MAP_SVH

// register byte offsets; bit 12 of the address selects the packet ram
`define UDTE_REG_STAT    13'h0000
`define UDTE_REG_INTERRUPT_STATUS_REG 13'h0004
`define UDTE_REG_INTMASK 13'h0008
`define UDTE_REG_ERROR_STATUS_REG 13'h000c
`define UDTE_REG_ERRMASK 13'h0010
`define UDTE_REG_MAXPKT  13'h0014
`define UDTE_RAM_SEL     12

// descriptor byte 0 fields
`define UDTE_BD_OWN      7
`define UDTE_BD_D01      6
`define UDTE_BD_DTS      3
`define UDTE_BD_HALT     2

// status bit positions
`define UDTE_INT_TOKDN   0
`define UDTE_INT_ERR     1
`define UDTE_ERR_BTO     0
`define UDTE_ERR_BUF     1

// reset values
`define UDTE_MAXP_RST    8'h40
`define UDTE_MASK_RST    2'h0

// packet ids
`define UDTE_PID_OUT     4'h1
`define UDTE_PID_IN      4'h9
`define UDTE_PID_SETUP   4'hd
`define UDTE_PID_ACK     4'h2
`define UDTE_PID_NAK     4'ha
`define UDTE_PID_STALL   4'he

`endif

// ===== usbdte_pkg.sv
package usbdte_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_RD0, S_RD1, S_RD2, S_CHK, S_TX, S_RX, S_WB0, S_WB1, S_DONE
   } usbdte_state_e;

   typedef struct packed {
      logic [3:0] pid;
      logic [2:0] ep;
      logic       odd;
      logic       iso;
   } usbdte_tok_s;
endpackage

// ===== usbdte_host_model.sv
module usbdte_host_model (
   input  wire logic                    clk_i,
   input  wire logic                    tok_ready_i,
   output      logic                    tok_valid_o,
   output      usbdte_pkg::usbdte_tok_s tok_o,
   output      logic                    rx_valid_o,
   output      logic [7:0]              rx_data_o,
   output      logic                    rx_end_o,
   input  wire logic                    tx_valid_i,
   input  wire logic [7:0]              tx_data_i,
   input  wire logic                    tx_last_i,
   output      logic                    tx_ready_o,
   input  wire logic                    hs_valid_i,
   input  wire logic [3:0]              hs_pid_i
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       slow = 1'b0;
   logic [3:0] hs_seen = 4'h0;
   logic       tx_end = 1'b0;
   logic       tok_late = 1'b0;
   logic [7:0] tx_q[$];

   initial begin
      tok_valid_o = 1'b0;
      tok_o = '0;
      rx_valid_o = 1'b0;
      rx_data_o = 8'h00;
      rx_end_o = 1'b0;
   end

   // a slow host takes every other byte, so the held tx byte is exercised
   always @(posedge clk_i) begin
      tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
      if (hs_valid_i) hs_seen <= hs_pid_i;
      if (tx_valid_i && tx_ready_o) tx_q.push_back(tx_data_i);
      if (tx_last_i && (tx_ready_o || !tx_valid_i)) tx_end <= 1'b1;
   end

   task automatic send_tok(input logic [3:0] pid, input logic [2:0] ep,
                           input logic odd);
      int n;
      n = 0;
      hs_seen = 4'h0;
      tx_q.delete();
      tx_end = 1'b0;
      while (tok_ready_i !== 1'b1 && n < 100) begin
         @(posedge clk_i);
         n++;
      end
      if (tok_ready_i !== 1'b1) tok_late = 1'b1;
      tok_valid_o <= 1'b1;
      tok_o <= '{pid: pid, ep: ep, odd: odd, iso: 1'b0};
      @(posedge clk_i);
      tok_valid_o <= 1'b0;
      tok_o <= ~tok_o;
   endtask

   // payload never above 64 bytes; a setup packet is sent as 8 bytes
   task automatic send_rx(input int cnt, input int gap,
                          input logic [7:0] base);
      for (int i = 0; i < cnt; i++) begin
         rx_valid_o <= 1'b1;
         rx_data_o <= base + i[7:0];
         @(posedge clk_i);
         if (gap > 1) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= ~(base + i[7:0]);
            repeat (gap - 1) @(posedge clk_i);
         end
      end
      rx_valid_o <= 1'b0;
      rx_end_o <= 1'b1;
      @(posedge clk_i);
      rx_end_o <= 1'b0;
   endtask
endmodule // usbdte_host_model

// ===== tb_usbdte_engine.sv
`include "usbdte_map.svh"

module tb_usbdte_engine;
   timeunit 1ns;
   timeprecision 1ns;
   logic                    clk_i, rst_i, cyc_i, stb_i, we_i;
   logic [12:0]             adr_i;
   logic [3:0]              sel_i;
   logic [31:0]             dat_i, dat_o, rd;
   logic                    ack_o, tok_valid_i, tok_ready_o, rx_valid_i;
   usbdte_pkg::usbdte_tok_s tok_i;
   logic [7:0]              rx_data_i, tx_data_o;
   logic                    rx_end_i, tx_valid_o, tx_last_o, tx_ready_i;
   logic                    hs_valid_o, irq_o;
   logic [3:0]              hs_pid_o;
   int                      n_mismatch, checked;

   usbdte_engine #(.RAM_AW(10), .MAXP_LIMIT(64)) u_dut (.*);
   usbdte_host_model u_host (.clk_i(clk_i), .tok_ready_i(tok_ready_o),
      .tok_valid_o(tok_valid_i), .tok_o(tok_i), .rx_valid_o(rx_valid_i),
      .rx_data_o(rx_data_i), .rx_end_o(rx_end_i), .tx_valid_i(tx_valid_o),
      .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i),
      .hs_valid_i(hs_valid_o), .hs_pid_i(hs_pid_o));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic tally_and_finish();
      if (u_host.tok_late) n_mismatch++;
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [12:0] ram(input logic [9:0] i);
      return {1'b1, i, 2'b00};
   endfunction

   function automatic logic [9:0] bdx(input logic [2:0] ep,
                                      input logic dir, odd);
      return {3'h0, ep, dir, odd, 2'b00};
   endfunction

   // one classic cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [12:0] a,
                     input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
      if (ack_o !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic rdr(input string what, input logic [12:0] a,
                      input logic [31:0] exp);
      wb(1'b0, a, 8'h00);
      chk(what, rd, exp);
   endtask

   task automatic arm(input logic [9:0] i, input logic [7:0] b0, b1, b2);
      wb(1'b1, ram(i + 10'h2), b2);
      wb(1'b1, ram(i + 10'h1), b1);
      wb(1'b1, ram(i), b0);
   endtask

   task automatic chk_bd(input logic [9:0] i, input logic [7:0] b0, b1, b2);
      rdr("descriptor ctrl", ram(i), {24'h0, b0});
      rdr("descriptor count", ram(i + 10'h1), {24'h0, b1});
      rdr("descriptor buffer", ram(i + 10'h2), {24'h0, b2});
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      repeat (2) @(posedge clk_i);
      while (tok_ready_o !== 1'b1 && n < 500) begin
         @(posedge clk_i);
         n++;
      end
      @(posedge clk_i);
      if (tok_ready_o !== 1'b1) begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask

   task automatic out_tok(input logic [2:0] ep, input logic odd,
                          input int cnt, input logic [7:0] base);
      u_host.send_tok(`UDTE_PID_OUT, ep, odd);
      repeat (5) @(posedge clk_i);
      u_host.send_rx(cnt, 2, base);
      wait_idle();
   endtask

   initial begin
      n_mismatch = 0;
      checked = 0;
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i} = 3'h0;
      adr_i = 13'h0000;
      sel_i = 4'h1;
      dat_i = 32'h0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rdr("max packet", `UDTE_REG_MAXPKT, 32'h40);
      rdr("int mask", `UDTE_REG_INTMASK, 32'h0);
      rdr("err mask", `UDTE_REG_ERRMASK, 32'h0);
      rdr("unmapped", 13'h0018, 32'h0);
      // setup on endpoint 0, token done unmasked
      wb(1'b1, `UDTE_REG_INTMASK, 8'h01);
      arm(bdx(3'h0, 1'b0, 1'b0), 8'h88, 8'h08, 8'h10);
      u_host.send_tok(`UDTE_PID_SETUP, 3'h0, 1'b0);
      repeat (5) @(posedge clk_i);
      u_host.send_rx(8, 2, 8'ha0);
      wait_idle();
      chk("setup hs", {28'h0, u_host.hs_seen}, 32'h2);
      chk_bd(bdx(3'h0, 1'b0, 1'b0), 8'h34, 8'h08, 8'h10);
      for (int k = 0; k < 8; k++)
         rdr("rx byte", ram(10'h100 + k[9:0]), {24'h0, 8'ha0 + k[7:0]});
      rdr("status", `UDTE_REG_STAT, 32'h0);
      rdr("int status", `UDTE_REG_INTERRUPT_STATUS_REG, 32'h1);
      chk("irq", {31'h0, irq_o}, 32'h1);
      wb(1'b1, `UDTE_REG_INTERRUPT_STATUS_REG, 8'h01);
      rdr("int status", `UDTE_REG_INTERRUPT_STATUS_REG, 32'h0);
      chk("irq", {31'h0, irq_o}, 32'h0);
      // in on endpoint 1 odd with a stalling host
      for (int k = 0; k < 3; k++)
         wb(1'b1, ram(10'h120 + k[9:0]), 8'h51 + k[7:0]);
      arm(bdx(3'h1, 1'b1, 1'b1), 8'hc0, 8'h03, 8'h12);
      u_host.slow = 1'b1;
      u_host.send_tok(`UDTE_PID_IN, 3'h1, 1'b1);
      wait_idle();
      u_host.slow = 1'b0;
      chk("tx count", 32'(u_host.tx_q.size()), 32'h3);
      for (int k = 0; k < 3; k++)
         chk("tx byte", {24'h0, u_host.tx_q[k]}, 8'h51 + k[7:0]);
      chk_bd(bdx(3'h1, 1'b1, 1'b1), 8'h64, 8'h03, 8'h12);
      rdr("status", `UDTE_REG_STAT, 32'h07);
      wb(1'b1, `UDTE_REG_INTERRUPT_STATUS_REG, 8'h01);
      // same descriptor now belongs to firmware
      u_host.send_tok(`UDTE_PID_IN, 3'h1, 1'b1);
      wait_idle();
      chk("not owned hs", {28'h0, u_host.hs_seen}, 32'ha);
      chk("not owned tx", 32'(u_host.tx_q.size()), 32'h0);
      rdr("int status", `UDTE_REG_INTERRUPT_STATUS_REG, 32'h0);
      // halted descriptor
      arm(bdx(3'h3, 1'b0, 1'b0), 8'h84, 8'h08, 8'h30);
      u_host.send_tok(`UDTE_PID_OUT, 3'h3, 1'b0);
      wait_idle();
      chk("halt hs", {28'h0, u_host.hs_seen}, 32'he);
      chk_bd(bdx(3'h3, 1'b0, 1'b0), 8'h84, 8'h08, 8'h30);
      // oversized packet against a small max packet size
      wb(1'b1, `UDTE_REG_MAXPKT, 8'h64);
      rdr("max clamp", `UDTE_REG_MAXPKT, 32'h40);
      wb(1'b1, `UDTE_REG_MAXPKT, 8'h04);
      wb(1'b1, `UDTE_REG_INTMASK, 8'h02);
      wb(1'b1, `UDTE_REG_ERRMASK, 8'h02);
      wb(1'b1, ram(10'h144), 8'h5a);
      arm(bdx(3'h2, 1'b0, 1'b1), 8'h80, 8'h08, 8'h14);
      out_tok(3'h2, 1'b1, 6, 8'hc0);
      chk("oversize hs", {28'h0, u_host.hs_seen}, 32'h2);
      chk_bd(bdx(3'h2, 1'b0, 1'b1), 8'h04, 8'h04, 8'h14);
      for (int k = 0; k < 4; k++)
         rdr("clip byte", ram(10'h140 + k[9:0]), {24'h0, 8'hc0 + k[7:0]});
      rdr("guard byte", ram(10'h144), 32'h5a);
      rdr("err status", `UDTE_REG_ERROR_STATUS_REG, 32'h2);
      rdr("int status", `UDTE_REG_INTERRUPT_STATUS_REG, 32'h3);
      chk("irq", {31'h0, irq_o}, 32'h1);
      wb(1'b1, `UDTE_REG_ERROR_STATUS_REG, 8'h02);
      wb(1'b1, `UDTE_REG_INTERRUPT_STATUS_REG, 8'h01);
      wb(1'b1, `UDTE_REG_MAXPKT, 8'h40);
      wb(1'b1, `UDTE_REG_ERRMASK, 8'h01);
      // back-to-back bytes overrun the single holding byte
      arm(bdx(3'h2, 1'b0, 1'b0), 8'h80, 8'h08, 8'h16);
      u_host.send_tok(`UDTE_PID_OUT, 3'h2, 1'b0);
      u_host.send_rx(4, 1, 8'h11);
      wait_idle();
      chk("overrun hs", {28'h0, u_host.hs_seen}, 32'ha);
      rdr("err status", `UDTE_REG_ERROR_STATUS_REG, 32'h1);
      rdr("int status", `UDTE_REG_INTERRUPT_STATUS_REG, 32'h2);
      chk_bd(bdx(3'h2, 1'b0, 1'b0), 8'h80, 8'h08, 8'h16);
      wb(1'b1, `UDTE_REG_ERROR_STATUS_REG, 8'h01);
      // zero-length in status phase after the setup
      arm(bdx(3'h0, 1'b1, 1'b0), 8'hc8, 8'h00, 8'h18);
      u_host.send_tok(`UDTE_PID_IN, 3'h0, 1'b0);
      wait_idle();
      chk("zlp count", 32'(u_host.tx_q.size()), 32'h0);
      chk("zlp end", {31'h0, u_host.tx_end}, 32'h1);
      chk_bd(bdx(3'h0, 1'b1, 1'b0), 8'h64, 8'h00, 8'h18);
      rdr("status", `UDTE_REG_STAT, 32'h02);
      tally_and_finish();
   end
endmodule // tb_usbdte_engine
